// >>> pkg/ulc_pkg.sv
package ulc_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_DIV_LO = 32'h5000_1100;
   localparam logic [31:0] ADDR_DIV_HI = 32'h5000_1104;
   localparam logic [31:0] ADDR_IIR_FCR = 32'h5000_1108;
   localparam logic [31:0] ADDR_LCR = 32'h5000_110C;
   localparam logic [31:0] ADDR_MCR = 32'h5000_1110;
   localparam logic [31:0] ADDR_STAT = 32'h5000_117C;
   localparam logic [31:0] ADDR_EVT = 32'h5000_1180;
   localparam logic [31:0] ADDR_MASK = 32'h5000_1184;
   // Identity / queue control fields
   localparam int FCR_DMA = 3;
   localparam int FCR_TXCLR = 2;
   localparam int FCR_RXCLR = 1;
   localparam int FCR_QEN = 0;
   localparam int IIR_QON_LO = 6;
   localparam logic QEN_RST = 1'b1;
   // Line control fields
   localparam int LCR_DIVACC = 7;
   localparam int LCR_BRK = 6;
   localparam int LCR_EPS = 4;
   localparam int LCR_PEN = 3;
   // Modem control fields
   localparam int MCR_LOOP = 4;
   localparam int MCR_IR = 6;
   // Port status field
   localparam int STAT_BUSY = 0;
   // Event status / mask fields
   localparam int EVT_W = 3;
   localparam int EVT_REFUSED = 0;
   localparam int EVT_QRESET = 1;
   localparam int EVT_BRK = 2;
   localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
   // Interrupt identity codes
   localparam logic [3:0] IID_NONE = 4'h1;
   localparam logic [3:0] IID_THR_EMPTY = 4'h2;
   localparam logic [3:0] IID_RX_AVAIL = 4'h4;
   localparam logic [3:0] IID_LINE_STAT = 4'h6;
   localparam logic [3:0] IID_BUSY = 4'h7;
   localparam logic [3:0] IID_CHAR_TMO = 4'hC;
   // Timing
   localparam int CLK_NS = 4;
   localparam int BRK_HALF_NS = 1000;
   localparam int BRK_HALF_CYC = (BRK_HALF_NS / CLK_NS < 1) ? 1 : BRK_HALF_NS / CLK_NS;
   localparam int BRK_CNT_W = 9;

   typedef enum logic [1:0]
   {
      ULC_ST_IDLE = 2'b00,
      ULC_ST_RWAIT = 2'b01,
      ULC_ST_RDONE = 2'b10
   } ulc_bus_st_t;

   // Parity bit that makes the count of ones even or odd
   function automatic logic ulc_parity(input logic [7:0] data, input logic even);
      ulc_parity = even ? (^data) : ~(^data);
   endfunction : ulc_parity
endpackage : ulc_pkg

// >>> design/ulc_iid_prio.sv
`timescale 1ns/100ps
module ulc_iid_prio
(
   input wire logic line_stat,
   input wire logic rx_avail,
   input wire logic char_tmo,
   input wire logic thr_empty,
   input wire logic busy_det,
   output logic [3:0] irq_identity_code
);
   import ulc_pkg::*;

   // Highest priority pending source wins
   always_comb
   begin
      if (line_stat)
         irq_identity_code = IID_LINE_STAT;
      else if (rx_avail)
         irq_identity_code = IID_RX_AVAIL;
      else if (char_tmo)
         irq_identity_code = IID_CHAR_TMO;
      else if (thr_empty)
         irq_identity_code = IID_THR_EMPTY;
      else if (busy_det)
         irq_identity_code = IID_BUSY;
      else
         irq_identity_code = IID_NONE;
   end
endmodule : ulc_iid_prio

// >>> design/ulc_line_drive.sv
`timescale 1ns/100ps
module ulc_line_drive
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic break_force,
   input wire logic loop_on,
   input wire logic ir_on,
   input wire logic tx_serial,
   input wire logic ir_tx_n,
   input wire logic ser_in,
   output logic ser_out,
   output logic ir_out_n,
   output logic rx_line
);
   import ulc_pkg::*;

   logic sin_meta_ff;
   logic sin_sync_ff;
   logic [BRK_CNT_W-1:0] cnt_ff;
   logic [BRK_CNT_W-1:0] nxt_cnt;
   logic pulse_ff;
   logic nxt_pulse;
   logic ser_out_ff;
   logic nxt_ser_out;
   logic ir_out_n_ff;
   logic nxt_ir_out_n;
   logic rx_line_ff;
   logic nxt_rx_line;

   // Break pulse train and pin muxing
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_pulse = pulse_ff;
      if (!(break_force && ir_on && !loop_on))
      begin
         nxt_cnt = '0;
         nxt_pulse = 1'b0;
      end
      else if (cnt_ff == BRK_CNT_W'(BRK_HALF_CYC - 1))
      begin
         nxt_cnt = '0;
         nxt_pulse = ~pulse_ff;
      end
      else
         nxt_cnt = cnt_ff + 1'b1;
      // Serial output: idle high in loopback even during break, spacing during break otherwise
      if (loop_on)
         nxt_ser_out = 1'b1;
      else if (break_force)
         nxt_ser_out = 1'b0;
      else
         nxt_ser_out = tx_serial;
      // Infrared output
      if (loop_on && (ir_on || break_force))
         nxt_ir_out_n = 1'b0;
      else if (!ir_on)
         nxt_ir_out_n = 1'b1;
      else if (break_force)
         nxt_ir_out_n = ~pulse_ff;
      else
         nxt_ir_out_n = ir_tx_n;
      // Receiver input, looped back internally in diagnostic mode
      if (loop_on)
         nxt_rx_line = break_force ? 1'b0 : tx_serial;
      else
         nxt_rx_line = sin_sync_ff;
   end

   // Register stage and input synchroniser
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sin_meta_ff <= 1'b1;
         sin_sync_ff <= 1'b1;
         cnt_ff <= '0;
         pulse_ff <= 1'b0;
         ser_out_ff <= 1'b1;
         ir_out_n_ff <= 1'b1;
         rx_line_ff <= 1'b1;
      end
      else
      begin
         sin_meta_ff <= ser_in;
         sin_sync_ff <= sin_meta_ff;
         cnt_ff <= nxt_cnt;
         pulse_ff <= nxt_pulse;
         ser_out_ff <= nxt_ser_out;
         ir_out_n_ff <= nxt_ir_out_n;
         rx_line_ff <= nxt_rx_line;
      end
   end

   assign ser_out = ser_out_ff;
   assign ir_out_n = ir_out_n_ff;
   assign rx_line = rx_line_ff;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_break_spacing: assert property (break_force && !loop_on |=> !ser_out)
      else $error("break did not hold output at spacing");
   chk_break_pulses: assert property ($rose(pulse_ff) |-> ##1 (!ir_out_n || !break_force))
      else $error("infrared output not pulsing during break");
   chk_loop_ir_low: assert property (loop_on && (ir_on || break_force) |=> !ir_out_n)
      else $error("infrared output not low in loopback");
   cov_ir_break: cover property (break_force && ir_on && !loop_on ##1 $fell(pulse_ff));
endmodule : ulc_line_drive

// >>> design/ulc_uart_ctrl.sv
`timescale 1ns/100ps
module ulc_uart_ctrl
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic port_busy,
   input wire logic src_line_stat,
   input wire logic src_rx_avail,
   input wire logic src_char_tmo,
   input wire logic src_thr_empty,
   input wire logic tx_serial,
   input wire logic ir_tx_n,
   input wire logic ser_in,
   input wire logic [7:0] tx_char,
   input wire logic [7:0] rx_char,
   input wire logic rx_par_bit,
   output logic ser_out,
   output logic ir_out_n,
   output logic rx_line,
   output logic tx_par_bit,
   output logic rx_par_err,
   output logic parity_on,
   output logic even_parity_select,
   output logic divisor_access_select,
   output logic [15:0] divisor,
   output logic queue_enable,
   output logic dma_signal_select,
   output logic tx_queue_clear,
   output logic rx_queue_clear,
   output logic irq
);
   import ulc_pkg::*;

   ulc_bus_st_t st_ff;
   ulc_bus_st_t nxt_st;
   logic wr_pend_ff;
   logic nxt_wr_pend;
   logic [31:0] addr_ff;
   logic [31:0] nxt_addr;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;
   logic accept;
   logic [7:0] lcr_ff;
   logic [7:0] nxt_lcr;
   logic [7:0] mcr_ff;
   logic [7:0] nxt_mcr;
   logic [7:0] dll_ff;
   logic [7:0] nxt_dll;
   logic [7:0] dlh_ff;
   logic [7:0] nxt_dlh;
   logic qen_ff;
   logic nxt_qen;
   logic dma_ff;
   logic nxt_dma;
   logic txclr_ff;
   logic nxt_txclr;
   logic rxclr_ff;
   logic nxt_rxclr;
   logic [EVT_W-1:0] evt_ff;
   logic [EVT_W-1:0] nxt_evt;
   logic [EVT_W-1:0] mask_ff;
   logic [EVT_W-1:0] nxt_mask;
   logic [EVT_W-1:0] evt_set;
   logic tx_par_ff;
   logic nxt_tx_par;
   logic rx_err_ff;
   logic nxt_rx_err;
   logic [3:0] iid;
   logic wr_fcr;
   logic wr_lcr;

   // Address phase taken when selected, the bus is ready and htrans marks an active transfer
   assign accept = hsel && hready && htrans[1] && (st_ff != ULC_ST_RWAIT);
   assign wr_fcr = wr_pend_ff && (addr_ff == ADDR_IIR_FCR);
   assign wr_lcr = wr_pend_ff && (addr_ff == ADDR_LCR);

   // Bus sequencing: writes zero-wait, reads one wait state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_wr_pend = 1'b0;
      nxt_addr = addr_ff;
      case (st_ff)
         ULC_ST_IDLE, ULC_ST_RDONE:
         begin
            nxt_st = ULC_ST_IDLE;
            if (accept)
            begin
               nxt_addr = {haddr[31:2], 2'b00};
               nxt_wr_pend = hwrite;
               nxt_st = hwrite ? ULC_ST_IDLE : ULC_ST_RWAIT;
            end
         end
         ULC_ST_RWAIT:
            nxt_st = ULC_ST_RDONE;
         default:
            nxt_st = ULC_ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff <= ULC_ST_IDLE;
         wr_pend_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
      end
      else
      begin
         st_ff <= nxt_st;
         wr_pend_ff <= nxt_wr_pend;
         addr_ff <= nxt_addr;
      end
   end

   assign hreadyout = (st_ff != ULC_ST_RWAIT);
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // Read data mux, registered during the wait state
   always_comb
   begin
      nxt_hrdata = hrdata_ff;
      if (st_ff == ULC_ST_RWAIT)
      begin
         nxt_hrdata = 32'h0000_0000;
         case (addr_ff)
            ADDR_DIV_LO:
               nxt_hrdata[7:0] = lcr_ff[LCR_DIVACC] ? dll_ff : 8'h00;
            ADDR_DIV_HI:
               nxt_hrdata[7:0] = lcr_ff[LCR_DIVACC] ? dlh_ff : 8'h00;
            ADDR_IIR_FCR:
            begin
               nxt_hrdata[3:0] = iid;
               nxt_hrdata[IIR_QON_LO+:2] = {2{qen_ff}};
            end
            ADDR_LCR:
               nxt_hrdata[7:0] = lcr_ff;
            ADDR_MCR:
               nxt_hrdata[7:0] = mcr_ff;
            ADDR_STAT:
               nxt_hrdata[STAT_BUSY] = port_busy;
            ADDR_EVT:
               nxt_hrdata[EVT_W-1:0] = evt_ff;
            ADDR_MASK:
               nxt_hrdata[EVT_W-1:0] = mask_ff;
            default:
               nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Register writes and their side effects
   always_comb
   begin
      nxt_lcr = lcr_ff;
      nxt_mcr = mcr_ff;
      nxt_dll = dll_ff;
      nxt_dlh = dlh_ff;
      nxt_qen = qen_ff;
      nxt_dma = dma_ff;
      nxt_mask = mask_ff;
      nxt_txclr = 1'b0;
      nxt_rxclr = 1'b0;
      evt_set = '0;
      if (wr_fcr)
      begin
         nxt_dma = hwdata[FCR_DMA];
         nxt_qen = hwdata[FCR_QEN];
         nxt_txclr = hwdata[FCR_TXCLR] || (hwdata[FCR_QEN] != qen_ff);
         nxt_rxclr = hwdata[FCR_RXCLR] || (hwdata[FCR_QEN] != qen_ff);
         evt_set[EVT_QRESET] = nxt_txclr || nxt_rxclr;
      end
      if (wr_lcr)
      begin
         nxt_lcr[LCR_BRK] = hwdata[LCR_BRK];
         evt_set[EVT_BRK] = hwdata[LCR_BRK] && !lcr_ff[LCR_BRK];
         if (!port_busy)
         begin
            nxt_lcr[LCR_DIVACC] = hwdata[LCR_DIVACC];
            nxt_lcr[LCR_EPS] = hwdata[LCR_EPS];
            nxt_lcr[LCR_PEN] = hwdata[LCR_PEN];
         end
         else
            evt_set[EVT_REFUSED] = 1'b1;
      end
      if (wr_pend_ff && addr_ff == ADDR_MCR)
      begin
         nxt_mcr[MCR_LOOP] = hwdata[MCR_LOOP];
         nxt_mcr[MCR_IR] = hwdata[MCR_IR];
      end
      if (wr_pend_ff && lcr_ff[LCR_DIVACC] && addr_ff == ADDR_DIV_LO)
         nxt_dll = hwdata[7:0];
      if (wr_pend_ff && lcr_ff[LCR_DIVACC] && addr_ff == ADDR_DIV_HI)
         nxt_dlh = hwdata[7:0];
      if (wr_pend_ff && addr_ff == ADDR_MASK)
         nxt_mask = hwdata[EVT_W-1:0];
      // Sticky events: a new event wins over a write-one clear
      nxt_evt = evt_ff;
      if (wr_pend_ff && addr_ff == ADDR_EVT)
         nxt_evt = evt_ff & ~hwdata[EVT_W-1:0];
      nxt_evt = nxt_evt | evt_set;
      // Parity generate and check
      nxt_tx_par = parity_on && ulc_parity(tx_char, lcr_ff[LCR_EPS]);
      nxt_rx_err = parity_on && (rx_par_bit != ulc_parity(rx_char, lcr_ff[LCR_EPS]));
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff <= 32'h0000_0000;
         lcr_ff <= 8'h00;
         mcr_ff <= 8'h00;
         dll_ff <= 8'h00;
         dlh_ff <= 8'h00;
         qen_ff <= QEN_RST;
         dma_ff <= 1'b0;
         txclr_ff <= 1'b0;
         rxclr_ff <= 1'b0;
         evt_ff <= EVT_RST;
         mask_ff <= EVT_RST;
         tx_par_ff <= 1'b0;
         rx_err_ff <= 1'b0;
      end
      else
      begin
         hrdata_ff <= nxt_hrdata;
         lcr_ff <= nxt_lcr;
         mcr_ff <= nxt_mcr;
         dll_ff <= nxt_dll;
         dlh_ff <= nxt_dlh;
         qen_ff <= nxt_qen;
         dma_ff <= nxt_dma;
         txclr_ff <= nxt_txclr;
         rxclr_ff <= nxt_rxclr;
         evt_ff <= nxt_evt;
         mask_ff <= nxt_mask;
         tx_par_ff <= nxt_tx_par;
         rx_err_ff <= nxt_rx_err;
      end
   end

   // Identity code from pending sources
   ulc_iid_prio u_prio
   (
      .line_stat(src_line_stat),
      .rx_avail(src_rx_avail),
      .char_tmo(src_char_tmo && qen_ff),
      .thr_empty(src_thr_empty),
      .busy_det(evt_ff[EVT_REFUSED]),
      .irq_identity_code(iid)
   );

   // Pin drivers for break, infrared and loopback
   ulc_line_drive u_line
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .break_force(lcr_ff[LCR_BRK]),
      .loop_on(mcr_ff[MCR_LOOP]),
      .ir_on(mcr_ff[MCR_IR]),
      .tx_serial(tx_serial),
      .ir_tx_n(ir_tx_n),
      .ser_in(ser_in),
      .ser_out(ser_out),
      .ir_out_n(ir_out_n),
      .rx_line(rx_line)
   );

   // Control outputs
   assign parity_on = lcr_ff[LCR_PEN];
   assign even_parity_select = lcr_ff[LCR_EPS];
   assign divisor_access_select = lcr_ff[LCR_DIVACC];
   assign divisor = {dlh_ff, dll_ff};
   assign queue_enable = qen_ff;
   assign dma_signal_select = dma_ff;
   assign tx_queue_clear = txclr_ff;
   assign rx_queue_clear = rxclr_ff;
   assign tx_par_bit = tx_par_ff;
   assign rx_par_err = rx_err_ff;
   assign irq = |(evt_ff & mask_ff);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_iid_none: assert property (st_ff == ULC_ST_RWAIT && addr_ff == ADDR_IIR_FCR
      && !src_line_stat && !src_rx_avail && !src_thr_empty && !evt_ff[EVT_REFUSED]
      && !src_char_tmo |=> hrdata[3:0] == IID_NONE)
      else $error("identity not none when nothing pending");
   chk_iid_line: assert property (st_ff == ULC_ST_RWAIT && addr_ff == ADDR_IIR_FCR
      && src_line_stat |=> hrdata[3:0] == IID_LINE_STAT)
      else $error("line status not top priority");
   chk_dma_mode: assert property (wr_fcr |=> dma_signal_select == $past(hwdata[FCR_DMA]))
      else $error("dma mode not taken");
   chk_txclr_pulse: assert property (wr_fcr && hwdata[FCR_TXCLR] |=> tx_queue_clear ##1
      (!tx_queue_clear || $past(wr_fcr)))
      else $error("transmit clear not a self-clearing pulse");
   chk_rxclr_pulse: assert property (wr_fcr && hwdata[FCR_RXCLR] |=> rx_queue_clear)
      else $error("receive clear missing");
   chk_qen_change: assert property (wr_fcr && hwdata[FCR_QEN] != queue_enable
      |=> tx_queue_clear && rx_queue_clear)
      else $error("queue enable change did not clear both queues");
   chk_busy_lock: assert property (wr_lcr && port_busy
      |=> $stable(divisor_access_select) && $stable(even_parity_select))
      else $error("locked field changed while busy");
   chk_div_gate: assert property (wr_pend_ff && addr_ff == ADDR_DIV_LO && !divisor_access_select
      |=> $stable(divisor))
      else $error("divisor written without access bit");
   chk_lcr_resv: assert property (lcr_ff[5] == 1'b0)
      else $error("reserved line-control bit set");
   chk_loop_rx: assert property (mcr_ff[MCR_LOOP] && lcr_ff[LCR_BRK] ##1
      mcr_ff[MCR_LOOP] && lcr_ff[LCR_BRK] |=> !rx_line)
      else $error("loopback break not seen by receiver");
   chk_par_gen: assert property (!parity_on |=> !tx_par_bit && !rx_par_err)
      else $error("parity active while disabled");
   chk_par_even: assert property (parity_on && even_parity_select && $stable(tx_char)
      |=> tx_par_bit == ^$past(tx_char))
      else $error("even parity bit wrong");

   cov_read_iid: cover property (st_ff == ULC_ST_RWAIT && addr_ff == ADDR_IIR_FCR);
   cov_refused: cover property (wr_lcr && port_busy);
   cov_irq: cover property ($rose(irq));
   cov_div_write: cover property (wr_pend_ff && divisor_access_select && addr_ff == ADDR_DIV_HI);
endmodule : ulc_uart_ctrl

// >>> tb/ulc_remote.sv
`timescale 1ns/100ps
module ulc_remote
#(
   parameter int BRK_MIN = 20
)
(
   input wire logic hclk,
   input wire logic ser_out,
   input wire logic send_space,
   output logic ser_in,
   output logic brk_seen
);
   int low_cnt = 0;
   // Far end rests at mark level unless told to send a space
   assign ser_in = send_space ? 1'b0 : 1'b1;
   // A long spacing run on the line counts as a received break
   always @(posedge hclk)
   begin
      low_cnt <= ser_out ? 0 : low_cnt + 1;
      brk_seen <= (low_cnt >= BRK_MIN);
   end
endmodule : ulc_remote

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
   import ulc_pkg::*;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic port_busy = 1'b0;
   logic [3:0] src = 4'h0;
   logic tx_serial = 1'b1;
   logic [7:0] tx_char = 8'h00;
   logic [7:0] rx_char = 8'h00;
   logic rx_par_bit = 1'b0;
   logic send_space = 1'b0;
   logic ser_in, brk_seen, hready, hresp, ser_out, ir_out_n, rx_line, tx_par_bit, rx_par_err;
   logic parity_on, even_parity_select, divisor_access_select, queue_enable, dma_signal_select;
   logic tx_queue_clear, rx_queue_clear, irq;
   logic [15:0] divisor;
   logic [31:0] hrdata, rd;
   int err_count = 0;
   int samples_checked = 0;

   // Free-running bus clock
   always #2 hclk = ~hclk;

   ulc_uart_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .port_busy(port_busy),
      .src_line_stat(src[3]), .src_rx_avail(src[2]), .src_char_tmo(src[1]),
      .src_thr_empty(src[0]), .tx_serial(tx_serial), .ir_tx_n(1'b1), .ser_in(ser_in),
      .tx_char(tx_char), .rx_char(rx_char), .rx_par_bit(rx_par_bit), .ser_out(ser_out),
      .ir_out_n(ir_out_n), .rx_line(rx_line), .tx_par_bit(tx_par_bit),
      .rx_par_err(rx_par_err), .parity_on(parity_on), .even_parity_select(even_parity_select),
      .divisor_access_select(divisor_access_select), .divisor(divisor),
      .queue_enable(queue_enable), .dma_signal_select(dma_signal_select),
      .tx_queue_clear(tx_queue_clear), .rx_queue_clear(rx_queue_clear), .irq(irq));

   ulc_remote remote (.hclk(hclk), .ser_out(ser_out), .send_space(send_space),
      .ser_in(ser_in), .brk_seen(brk_seen));

   // Prints the counts and the verdict, then ends the run
   task automatic stop_test();
      $display("Counts: %0d mismatches in %0d comparisons", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One single transfer; read data lands in rd, waits are bounded
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      rd = hrdata;
      if (n >= 20)
      begin
         err_count++;
         stop_test();
      end
   endtask : bus

   // Values straight after reset
   task automatic t_reset();
      check("queue_enable", 32'(queue_enable), ONE);
      check("ser_out", 32'(ser_out), ONE);
      bus(ADDR_IIR_FCR, 1'b0, ZERO);
      check("iid_reset", rd, 32'h0000_00C1);
      bus(ADDR_LCR, 1'b0, ZERO);
      check("lcr_reset", rd, ZERO);
   endtask : t_reset

   // Lower sources are masked by higher ones as they drop away
   task automatic t_iid();
      logic [3:0] code [4] = '{IID_LINE_STAT, IID_RX_AVAIL, IID_CHAR_TMO, IID_THR_EMPTY};
      for (int i = 0; i < 5; i++)
      begin
         @(posedge hclk);
         src <= 4'b1111 >> i;
         bus(ADDR_IIR_FCR, 1'b0, ZERO);
         check("iid", 32'(rd[3:0]), 32'((i < 4) ? code[i] : IID_NONE));
      end
   endtask : t_iid

   // Queue control writes: {dma, tx clear, rx clear, enable}
   task automatic t_fcr();
      logic [3:0] wv [6] = '{4'h9, 4'h5, 4'h3, 4'h0, 4'h0, 4'h1};
      logic [3:0] ev [6] = '{4'h9, 4'h5, 4'h3, 4'h6, 4'h0, 4'h7};
      for (int i = 0; i < 6; i++)
      begin
         bus(ADDR_IIR_FCR, 1'b1, 32'(wv[i]));
         #1;
         check("fcr", 32'({dma_signal_select, tx_queue_clear, rx_queue_clear, queue_enable}),
            32'(ev[i]));
         @(posedge hclk);
         #1;
         check("clr_self", 32'({tx_queue_clear, rx_queue_clear}), ZERO);
      end
      // Timeout source is ignored while the queues are off
      @(posedge hclk);
      src <= 4'b0010;
      bus(ADDR_IIR_FCR, 1'b1, ZERO);
      bus(ADDR_IIR_FCR, 1'b0, ZERO);
      check("tmo_qoff", rd, ONE);
      src <= 4'b0000;
      bus(ADDR_IIR_FCR, 1'b1, ONE);
      bus(ADDR_EVT, 1'b0, ZERO);
      check("evt_qrst", rd, 32'h0000_0002);
   endtask : t_fcr

   // Divisor window, reserved bits and parity selection
   task automatic t_lcr();
      logic [31:0] lv [3] = '{32'h0000_0018, 32'h0000_0008, 32'h0000_0000};
      logic [1:0] pv [3] = '{2'b01, 2'b10, 2'b00};
      bus(ADDR_LCR, 1'b1, 32'h0000_0080);
      bus(ADDR_DIV_LO, 1'b1, 32'h0000_0034);
      bus(ADDR_DIV_HI, 1'b1, 32'h0000_0012);
      #1;
      check("divisor", 32'(divisor), 32'h0000_1234);
      bus(ADDR_DIV_LO, 1'b0, ZERO);
      check("div_lo", rd, 32'h0000_0034);
      bus(ADDR_LCR, 1'b1, 32'hFFFF_FF38);
      bus(ADDR_LCR, 1'b0, ZERO);
      check("lcr_rsvd", rd, 32'h0000_0018);
      check("lcr_bits", 32'({divisor_access_select, even_parity_select, parity_on}),
         32'h0000_0003);
      bus(ADDR_DIV_HI, 1'b0, ZERO);
      check("div_closed", rd, ZERO);
      bus(ADDR_DIV_LO, 1'b1, 32'h0000_0055);
      #1;
      check("div_locked", 32'(divisor), 32'h0000_1234);
      tx_char <= 8'h03;
      rx_char <= 8'h03;
      rx_par_bit <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         bus(ADDR_LCR, 1'b1, lv[i]);
         @(posedge hclk);
         #1;
         check("parity", 32'({tx_par_bit, rx_par_err}), 32'(pv[i]));
      end
   endtask : t_lcr

   // Busy port refuses line settings and raises the busy event
   task automatic t_busy();
      bus(ADDR_EVT, 1'b1, 32'h0000_0007);
      bus(ADDR_MASK, 1'b1, ONE);
      @(posedge hclk);
      port_busy <= 1'b1;
      bus(ADDR_LCR, 1'b1, 32'h0000_0098);
      #1;
      check("irq_busy", 32'(irq), ONE);
      check("hresp_ok", 32'(hresp), ZERO);
      bus(ADDR_LCR, 1'b0, ZERO);
      check("lcr_locked", rd, ZERO);
      check("lock_bits", 32'({divisor_access_select, even_parity_select, parity_on}),
         ZERO);
      bus(ADDR_IIR_FCR, 1'b0, ZERO);
      check("iid_busy", 32'(rd[3:0]), 32'(IID_BUSY));
      bus(ADDR_MASK, 1'b1, ZERO);
      #1;
      check("irq_masked", 32'(irq), ZERO);
      bus(ADDR_MASK, 1'b1, ONE);
      bus(ADDR_EVT, 1'b1, ONE);
      #1;
      check("irq_cleared", 32'(irq), ZERO);
      @(posedge hclk);
      port_busy <= 1'b0;
      bus(ADDR_LCR, 1'b1, 32'h0000_0098);
      bus(ADDR_LCR, 1'b0, ZERO);
      check("lcr_idle", rd, 32'h0000_0098);
      check("idle_bits", 32'({divisor_access_select, even_parity_select, parity_on}),
         32'h0000_0007);
      bus(ADDR_LCR, 1'b1, ZERO);
   endtask : t_busy

   // Break on the line, in infrared and in loopback
   task automatic t_break();
      logic v;
      int n;
      bus(ADDR_LCR, 1'b1, 32'h0000_0040);
      @(posedge hclk);
      #1;
      check("ser_out_brk", 32'(ser_out), ZERO);
      repeat (25) @(posedge hclk);
      check("far_brk", 32'(brk_seen), ONE);
      bus(ADDR_EVT, 1'b0, ZERO);
      check("evt_brk", rd, 32'h0000_0004);
      bus(ADDR_MCR, 1'b1, 32'h0000_0040);
      v = ir_out_n;
      for (n = 0; n < 600 && ir_out_n === v; n++) @(posedge hclk);
      v = ir_out_n;
      for (n = 0; n < 600 && ir_out_n === v; n++) @(posedge hclk);
      check("ir_half", 32'(n), 32'(BRK_HALF_CYC));
      bus(ADDR_MCR, 1'b1, 32'h0000_0050);
      @(posedge hclk);
      #1;
      check("loop_brk", 32'({ir_out_n, rx_line}), ZERO);
      // Loopback break with infrared off still pulls the infrared pin low
      bus(ADDR_MCR, 1'b1, 32'h0000_0010);
      @(posedge hclk);
      #1;
      check("loop_brk_nir", 32'({ir_out_n, rx_line, ser_out}), ONE);
      bus(ADDR_LCR, 1'b1, ZERO);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge hclk);
         tx_serial <= i[0];
         repeat (2) @(posedge hclk);
         #1;
         check("loop_data", 32'(rx_line), 32'(i[0]));
      end
      bus(ADDR_MCR, 1'b1, ZERO);
      @(posedge hclk);
      send_space <= 1'b1;
      repeat (5) @(posedge hclk);
      #1;
      check("rx_pin", 32'(rx_line), ZERO);
   endtask : t_break

   // Main sequence
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_iid();
      t_fcr();
      t_lcr();
      t_busy();
      t_break();
      stop_test();
   end
endmodule : tb
